//--- hw/dma_command_and_transfer_counter.sv
// dma command decoder, external bus sequencer and transfer counter
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "dma_cmd_consts.svh"
module dma_command_and_transfer_counter
   import dma_cmd_pkg::*;
(
   input wire logic mclk_in, // core clock
   input wire logic rst_in, // sync reset
   input wire logic bus_reset_in, // usb bus reset pulse
   input wire logic [7:0] addr_in, // register address
   input wire logic [7:0] wr_data_in, // register write data
   input wire logic wr_in, // write strobe
   input wire logic rd_in, // read strobe
   output logic [7:0] rd_data_out, // read data, next cycle
   input wire logic [15:0] data_in, // dma data pins in
   output logic [15:0] data_out, // dma data pins out
   output logic data_oe_out, // dma data drive enable
   output logic dreq_out, // generic request to controller
   input wire logic dack_in, // generic acknowledge
   input wire logic diow_in, // generic write strobe
   input wire logic dior_in, // generic read strobe
   input wire logic eot_in, // end_of_transfer_input
   output logic ata_dior_out, // drive read strobe
   output logic ata_diow_out, // drive write strobe
   output logic ata_dmack_out, // drive dma acknowledge
   input wire logic ata_dmarq_in, // drive dma request
   input wire logic iordy_in, // drive ready
   output logic [2:0] tf_addr_out, // task-file register select
   input wire logic buf_space_in, // buffer can take a word
   input wire logic buf_avail_in, // buffer holds a word
   input wire logic [15:0] buf_rdata_in, // buffer head word
   output logic buf_wr_out, // push pulse
   output logic [15:0] buf_wdata_out, // pushed word
   output logic buf_rd_out, // pop pulse
   output logic buf_validate_out, // validate packet pulse
   output logic buf_clear_out, // clear buffer pulse
   output logic buf_restart_out, // pointer restart pulse
   output logic core_reset_out, // core reset done pulse
   output logic cmd_irq_out // command complete event
);
   core_t q;
   core_t n;
   logic [31:0] count;
   logic zero;
   logic dec;
   logic cnt_clr;
   logic cnt_wr;
   logic cmd_wr;
   logic is_generic_slave_dma;
   logic is_mdma;
   logic is_ata_dma;
   logic is_rd;
   logic counted;
   logic buf_ok;
   logic start_ok;
   logic generic_slave_dma_wr_edge;
   logic generic_slave_dma_rd_edge;
   logic eot_edge;
   logic [1:0] step;

   // ***********************************
   // decode of the running command
   // ***********************************
   assign cmd_wr = wr_in && (addr_in == `ADDR_CMD);
   assign cnt_wr = wr_in && (addr_in >= `ADDR_CNT0) && (addr_in <= `ADDR_CNT3);
   assign is_generic_slave_dma = (q.cmd == `CMD_GENERIC_SLAVE_DMA_IN) || (q.cmd == `CMD_GENERIC_SLAVE_DMA_OUT);
   assign is_mdma = (q.cmd == `CMD_MDMA_RD) || (q.cmd == `CMD_MDMA_WR);
   assign is_ata_dma = is_mdma || (q.cmd == `CMD_UDMA_RD) || (q.cmd == `CMD_UDMA_WR);
   assign is_rd = !((q.cmd == `CMD_GENERIC_SLAVE_DMA_OUT) || (q.cmd == `CMD_UDMA_WR) ||
                    (q.cmd == `CMD_PIO_WR) || (q.cmd == `CMD_MDMA_WR));
   assign counted = (q.cmd <= `CMD_MDMA_WR) &&
                    !(is_generic_slave_dma && q.cfg_lo[`CFG_CNT_DIS_BIT]);
   assign step = (is_generic_slave_dma && !q.cfg_lo[`CFG_WIDTH_BIT]) ? 2'h1 : 2'h2;
   assign buf_ok = is_rd ? buf_space_in : buf_avail_in;
   // pio and task-file cycles wait on ready and the buffer; request and acknowledge unused
   assign start_ok = buf_ok && (is_ata_dma ? q.p2[`PIN_DMARQ] : q.p2[`PIN_IORDY]);
   assign generic_slave_dma_wr_edge = q.p2[`PIN_DIOW] && !q.p3[`PIN_DIOW] && q.p2[`PIN_DACK];
   assign generic_slave_dma_rd_edge = !q.p2[`PIN_DIOR] && q.p3[`PIN_DIOR] && q.p2[`PIN_DACK];
   assign eot_edge = q.p2[`PIN_EOT] && !q.p3[`PIN_EOT];

   xfer_counter u_counter (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .clr_in(cnt_clr),
      .wr_in(cnt_wr),
      .sel_in(addr_in[1:0]),
      .wdata_in(wr_data_in),
      .dec_in(dec),
      .step_in(step),
      .count_out(count),
      .zero_out(zero)
   );

   // ***********************************
   // next state
   // ***********************************
   always_comb begin
      n = q;
      n.p1 = {eot_in, ata_dmarq_in, iordy_in, dior_in, diow_in, dack_in};
      n.p2 = q.p1;
      n.p3 = q.p2;
      n.d1 = data_in;
      n.d2 = q.d1;
      n.bwr = 1'b0;
      n.brd = 1'b0;
      n.bval = 1'b0;
      n.bclr = 1'b0;
      n.brst = 1'b0;
      n.irq = 1'b0;
      n.creset = 1'b0;
      n.rdata = 8'h00;
      dec = 1'b0;
      cnt_clr = bus_reset_in;
      if (rd_in) begin
         case (addr_in)
            `ADDR_CMD: n.rdata = `CMD_READ_VALUE;
            8'h34: n.rdata = count[7:0];
            8'h35: n.rdata = count[15:8];
            8'h36: n.rdata = count[23:16];
            8'h37: n.rdata = count[31:24];
            `ADDR_CFG_LO: n.rdata = q.cfg_lo;
            `ADDR_CFG_HI: n.rdata = q.cfg_hi;
            `ADDR_STATUS: n.rdata = {q.st != ST_IDLE, zero, q.ran, 2'h0, 3'(q.st)};
            default: n.rdata = 8'h00;
         endcase
      end
      if (wr_in && (addr_in == `ADDR_CFG_LO)) begin
         n.cfg_lo = wr_data_in;
      end
      if (wr_in && (addr_in == `ADDR_CFG_HI)) begin
         n.cfg_hi = wr_data_in;
      end
      unique case (q.st)
         ST_IDLE: begin
            n.dreq = 1'b0;
            n.doe = 1'b0;
         end
         ST_GENERIC_SLAVE_DMA: begin
            n.dreq = buf_ok && (!counted || !zero);
            n.dout = buf_rdata_in;
            if (q.cmd == `CMD_GENERIC_SLAVE_DMA_IN) begin
               if (generic_slave_dma_wr_edge) begin
                  n.bwr = 1'b1;
                  n.bwdata = q.d2;
                  dec = counted;
               end
            end else begin
               n.doe = q.p2[`PIN_DACK] && q.p2[`PIN_DIOR];
               if (generic_slave_dma_rd_edge) begin
                  n.brd = 1'b1;
                  dec = counted;
               end
            end
            if ((q.cmd == `CMD_GENERIC_SLAVE_DMA_IN) && !counted && eot_edge) begin
               n.st = ST_IDLE;
               n.bval = 1'b1;
               n.dreq = 1'b0;
            end else if (counted && zero) begin
               n.st = ST_IDLE;
               n.bval = (q.cmd == `CMD_GENERIC_SLAVE_DMA_IN);
               n.dreq = 1'b0;
               n.doe = 1'b0;
            end
         end
         ST_WAIT: begin
            if (counted && zero) begin
               n.st = ST_IDLE;
            end else if (start_ok) begin
               n.st = ST_STROBE;
               n.tmr = 4'(`STROBE_CYC - 1);
               n.dmack = is_ata_dma;
               n.dior = is_rd;
               n.diow = !is_rd;
               if (!is_rd) begin
                  n.doe = 1'b1;
                  n.dout = buf_rdata_in;
                  n.brd = 1'b1;
               end
            end
         end
         ST_STROBE: begin
            if (q.tmr != 4'h0) begin
               n.tmr = q.tmr - 4'h1;
            end else begin
               n.dior = 1'b0;
               n.diow = 1'b0;
               n.dmack = 1'b0;
               n.doe = 1'b0;
               n.st = ST_RECOVER;
               n.tmr = 4'(`RECOVER_CYC - 1);
               dec = counted;
               if (q.cmd == `CMD_POLL_BUSY) begin
                  if (!q.d2[`DRIVE_BUSY_BIT]) begin
                     n.irq = 1'b1;
                     n.st = ST_IDLE;
                  end
               end else if (is_rd) begin
                  n.bwr = 1'b1;
                  n.bwdata = q.d2;
               end
               if (q.cmd == `CMD_TF_DATA) begin
                  n.st = ST_IDLE;
               end
               if (q.cmd == `CMD_TF_ALL) begin
                  if (q.tf == `TF_LAST) begin
                     n.irq = 1'b1;
                     n.st = ST_IDLE;
                  end else begin
                     n.tf = q.tf + 3'h1;
                  end
               end
            end
         end
         ST_RECOVER: begin
            if (q.tmr != 4'h0) begin
               n.tmr = q.tmr - 4'h1;
            end else begin
               n.st = ST_WAIT;
            end
         end
         ST_RESET: begin
            // handshake pins pulse while the core resets
            n.dreq = 1'b1;
            n.dior = 1'b1;
            n.diow = 1'b1;
            n.dmack = 1'b1;
            n.doe = 1'b0;
            if (q.tmr != 4'h0) begin
               n.tmr = q.tmr - 4'h1;
            end else begin
               n.st = ST_IDLE;
               n.dreq = 1'b0;
               n.dior = 1'b0;
               n.diow = 1'b0;
               n.dmack = 1'b0;
               n.cmd = `CMD_READ_VALUE;
               n.cfg_lo = `CFG_LO_RESET;
               n.cfg_hi = `CFG_HI_RESET;
               n.tf = `TF_DATA;
               n.ran = 1'b0;
               n.creset = 1'b1;
               cnt_clr = 1'b1;
            end
         end
      endcase
      // ***********************************
      // command register writes
      // ***********************************
      if (cmd_wr) begin
         if (wr_data_in == `CMD_CORE_RESET) begin
            n.st = ST_RESET;
            n.tmr = 4'(`RST_PULSE_CYC - 1);
         end else if ((wr_data_in == `CMD_MDMA_STOP) && is_mdma &&
                      (q.st != ST_IDLE) && (q.st != ST_RESET)) begin
            n.st = ST_IDLE;
            n.dior = 1'b0;
            n.diow = 1'b0;
            n.dmack = 1'b0;
            n.doe = 1'b0;
         end else if (q.st == ST_IDLE) begin
            case (wr_data_in)
               `CMD_GENERIC_SLAVE_DMA_IN, `CMD_GENERIC_SLAVE_DMA_OUT: begin
                  n.st = ST_GENERIC_SLAVE_DMA;
                  n.cmd = wr_data_in;
                  n.ran = 1'b1;
               end
               `CMD_UDMA_RD, `CMD_UDMA_WR, `CMD_PIO_RD, `CMD_PIO_WR,
               `CMD_MDMA_RD, `CMD_MDMA_WR: begin
                  n.st = ST_WAIT;
                  n.cmd = wr_data_in;
                  n.tf = `TF_DATA;
                  n.ran = 1'b1;
               end
               `CMD_TF_DATA: begin
                  n.st = ST_WAIT;
                  n.cmd = wr_data_in;
                  n.tf = `TF_DATA;
                  n.ran = 1'b1;
               end
               `CMD_POLL_BUSY: begin
                  n.st = ST_WAIT;
                  n.cmd = wr_data_in;
                  n.tf = `TF_STATUS;
                  n.ran = 1'b1;
               end
               `CMD_TF_ALL: begin
                  n.st = ST_WAIT;
                  n.cmd = wr_data_in;
                  n.tf = `TF_FIRST;
                  n.ran = 1'b1;
               end
               `CMD_VALIDATE: n.bval = 1'b1;
               `CMD_CLEAR: n.bclr = 1'b1;
               `CMD_RESTART: n.brst = 1'b1;
               default: n.cmd = q.cmd;
            endcase
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         q <= '0;
         q.st <= ST_IDLE;
         q.cmd <= `CMD_READ_VALUE;
         q.cfg_lo <= `CFG_LO_RESET;
         q.cfg_hi <= `CFG_HI_RESET;
      end else begin
         q <= n;
      end
   end

   // ***********************************
   // outputs
   // ***********************************
   assign rd_data_out = q.rdata;
   assign data_out = q.dout;
   assign data_oe_out = q.doe;
   assign dreq_out = q.dreq;
   assign ata_dior_out = q.dior;
   assign ata_diow_out = q.diow;
   assign ata_dmack_out = q.dmack;
   assign tf_addr_out = q.tf;
   assign buf_wr_out = q.bwr;
   assign buf_wdata_out = q.bwdata;
   assign buf_rd_out = q.brd;
   assign buf_validate_out = q.bval;
   assign buf_clear_out = q.bclr;
   assign buf_restart_out = q.brst;
   assign core_reset_out = q.creset;
   assign cmd_irq_out = q.irq;

   // ***********************************
   // checks
   // ***********************************
   localparam int RST_A = `RST_PULSE_CYC;

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);

   cmd_reads_ff_a: assert property (rd_in && addr_in == `ADDR_CMD |=> rd_data_out == 8'hff)
      else $error("command register did not read as ff");
   idle_no_drive_a: assert property (q.st == ST_IDLE && !$past(q.st == ST_STROBE) |-> !data_oe_out)
      else $error("data bus driven while idle");
   reserved_code_a: assert property (cmd_wr && q.st == ST_IDLE && (wr_data_in == 8'h0d ||
      wr_data_in > 8'h12) |=> q.st == ST_IDLE && $stable(q.cmd))
      else $error("reserved command changed state");
   pio_ready_wait_a: assert property (q.st == ST_WAIT && !is_ata_dma && !q.p2[`PIN_IORDY]
      && !cmd_wr |=> q.st != ST_STROBE)
      else $error("pio cycle began without ready");
   count_top_load_a: assert property (cnt_wr && addr_in == `ADDR_CNT3 && !bus_reset_in
      |=> count[31:24] == $past(wr_data_in))
      else $error("count not loaded on top byte");
   mdma_stop_a: assert property (cmd_wr && wr_data_in == `CMD_MDMA_STOP && is_mdma
      && q.st == ST_STROBE |=> q.st == ST_IDLE && !ata_dior_out && !ata_diow_out)
      else $error("multiword stop did not halt");
   reset_pulse_a: assert property (cmd_wr && wr_data_in == `CMD_CORE_RESET
      |=> ##1 dreq_out && ata_dmack_out ##[1:RST_A] core_reset_out)
      else $error("core reset sequence wrong");
   bus_reset_clr_a: assert property (bus_reset_in |=> count == 32'h0)
      else $error("bus reset left count set");
   irq_source_a: assert property (cmd_irq_out |-> q.cmd == `CMD_POLL_BUSY
      || q.cmd == `CMD_TF_ALL)
      else $error("interrupt from wrong command");
   pio_word_step_a: assert property (q.st == ST_STROBE && q.tmr == 4'h0 && counted
      && !is_generic_slave_dma && count > 32'h2 |=> count == $past(count) - 32'h2)
      else $error("pio word did not count two bytes");

   generic_slave_dma_in_c: cover property (q.st == ST_GENERIC_SLAVE_DMA && buf_wr_out);
   tf_all_done_c: cover property (cmd_irq_out && q.cmd == `CMD_TF_ALL);
   eot_end_c: cover property (q.st == ST_GENERIC_SLAVE_DMA && !counted ##1 buf_validate_out);
endmodule : dma_command_and_transfer_counter
`default_nettype wire

//--- hw/dma_cmd_consts.svh
// offsets, fields, reset values, command codes and timing counts of the dma command block
`ifndef DMA_CMD_CONSTS_SVH
`define DMA_CMD_CONSTS_SVH

// ***********************************
// register offsets
// ***********************************
`define ADDR_CMD 8'h30
`define ADDR_CNT0 8'h34
`define ADDR_CNT3 8'h37
`define ADDR_CFG_LO 8'h38
`define ADDR_CFG_HI 8'h39
`define ADDR_STATUS 8'h3c

// ***********************************
// fields and reset values
// ***********************************
`define CFG_WIDTH_BIT 0
`define CFG_CNT_DIS_BIT 7
`define CFG_ATA_BIT 5
`define CFG_LO_RESET 8'h01
`define CFG_HI_RESET 8'h00
`define CNT_RESET 32'h00000000
`define CMD_READ_VALUE 8'hff
`define DRIVE_BUSY_BIT 7
`define TF_DATA 3'h0
`define TF_FIRST 3'h1
`define TF_LAST 3'h6
`define TF_STATUS 3'h7
`define PIN_DACK 0
`define PIN_DIOW 1
`define PIN_DIOR 2
`define PIN_IORDY 3
`define PIN_DMARQ 4
`define PIN_EOT 5

// ***********************************
// command codes
// ***********************************
`define CMD_GENERIC_SLAVE_DMA_IN 8'h00
`define CMD_GENERIC_SLAVE_DMA_OUT 8'h01
`define CMD_UDMA_RD 8'h02
`define CMD_UDMA_WR 8'h03
`define CMD_PIO_RD 8'h04
`define CMD_PIO_WR 8'h05
`define CMD_MDMA_RD 8'h06
`define CMD_MDMA_WR 8'h07
`define CMD_TF_DATA 8'h0a
`define CMD_POLL_BUSY 8'h0b
`define CMD_TF_ALL 8'h0c
`define CMD_VALIDATE 8'h0e
`define CMD_CLEAR 8'h0f
`define CMD_RESTART 8'h10
`define CMD_CORE_RESET 8'h11
`define CMD_MDMA_STOP 8'h12

// ***********************************
// timing
// ***********************************
`define CLK_PERIOD_NS 10
`define T_STROBE_NS 70
`define T_RECOVER_NS 30
`define T_RST_PULSE_NS 40
`define STROBE_CYC ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_CYC ((`T_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_PULSE_CYC ((`T_RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- hw/dma_cmd_pkg.sv
// types of the dma command block
package dma_cmd_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_GENERIC_SLAVE_DMA, ST_WAIT, ST_STROBE, ST_RECOVER, ST_RESET} state_t;

   typedef struct packed {
      state_t st;
      logic [7:0] cmd;
      logic [3:0] tmr;
      logic [2:0] tf;
      logic [7:0] cfg_lo;
      logic [7:0] cfg_hi;
      logic [5:0] p1;
      logic [5:0] p2;
      logic [5:0] p3;
      logic [15:0] d1;
      logic [15:0] d2;
      logic [7:0] rdata;
      logic [15:0] dout;
      logic doe;
      logic dreq;
      logic dior;
      logic diow;
      logic dmack;
      logic bwr;
      logic brd;
      logic bval;
      logic bclr;
      logic brst;
      logic irq;
      logic creset;
      logic [15:0] bwdata;
      logic ran;
   } core_t;

   typedef struct packed {
      logic [23:0] shadow;
      logic [31:0] count;
   } cnt_t;
endpackage : dma_cmd_pkg

//--- hw/xfer_counter.sv
// byte-wide loaded transfer counter with remaining-count decrement
`timescale 1ns/10ps
`default_nettype none
`include "dma_cmd_consts.svh"
module xfer_counter
   import dma_cmd_pkg::*;
(
   input wire logic mclk_in, // core clock
   input wire logic rst_in, // sync reset
   input wire logic clr_in, // bus or core reset
   input wire logic wr_in, // byte write
   input wire logic [1:0] sel_in, // byte lane
   input wire logic [7:0] wdata_in, // byte value
   input wire logic dec_in, // one word moved
   input wire logic [1:0] step_in, // bytes per word
   output logic [31:0] count_out, // bytes remaining
   output logic zero_out // nothing left
);
   cnt_t q;
   cnt_t n;

   always_comb begin
      n = q;
      if (dec_in) begin
         n.count = (q.count > {30'h0, step_in}) ? q.count - {30'h0, step_in} : 32'h0;
      end
      if (wr_in) begin
         unique case (sel_in)
            2'h0: n.shadow[7:0] = wdata_in;
            2'h1: n.shadow[15:8] = wdata_in;
            2'h2: n.shadow[23:16] = wdata_in;
            2'h3: n.count = {wdata_in, q.shadow};
         endcase
      end
      if (clr_in) begin
         n.shadow = 24'h0;
         n.count = `CNT_RESET;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         q <= '{shadow: 24'h0, count: `CNT_RESET};
      end else begin
         q <= n;
      end
   end

   assign count_out = q.count;
   assign zero_out = (q.count == 32'h0);
endmodule : xfer_counter
`default_nettype wire

//--- bench/ata_drive_model.sv
// attached drive model answering the block's task-file and data read strobes
`timescale 1ns/10ps
`default_nettype none
module ata_drive_model #(
   parameter int BUSY_READS = 2
) (
   input wire logic mclk_in, // core clock
   input wire logic rst_in, // sync reset
   input wire logic dior_in, // read strobe from block
   input wire logic [2:0] tf_in, // register select
   output logic [15:0] data_out, // bus toward block
   output logic iordy_out, // drive ready
   output logic dmarq_out // dma request
);
   logic dior_q;
   logic [7:0] words_q;
   logic [15:0] last_q;
   int busy_q;
   logic [15:0] word;
   // dma request follows ready so dma cycles can start
   assign dmarq_out = iordy_out;
   assign word = (tf_in == 3'h7) ? {8'h00, (busy_q > 0), 7'h00} : {8'ha5, words_q};
   // released bus shows the inverse of the last word
   assign data_out = dior_in ? word : ~last_q;
   always_ff @(posedge mclk_in) begin
      dior_q <= dior_in;
      if (rst_in) begin
         words_q <= 8'h00;
         busy_q <= BUSY_READS;
         iordy_out <= 1'b0;
         last_q <= 16'h0000;
      end else begin
         // slow answer: not ready during a strobe and one cycle after
         iordy_out <= ~dior_in & ~dior_q;
         if (dior_in) last_q <= word;
         if (dior_q & ~dior_in & tf_in == 3'h7 & busy_q > 0) busy_q <= busy_q - 1;
         if (dior_q & ~dior_in & tf_in != 3'h7) words_q <= words_q + 8'h01;
      end
   end
endmodule : ata_drive_model
`default_nettype wire

//--- bench/dma_command_and_transfer_counter_tb.sv
// self-checking testbench of the dma command block
`timescale 1ns/10ps
`default_nettype none
module dma_command_and_transfer_counter_tb;
   logic mclk_in = 0, rst_in = 1, bus_reset_in = 0, wr_in = 0, rd_in = 0;
   logic dack_in = 0, diow_in = 0, dior_in = 0, eot_in = 0, buf_space_in = 1, buf_avail_in = 1;
   logic [7:0] addr_in = 0, wr_data_in = 0, rd_data_out;
   logic [15:0] data_in, data_out, buf_rdata_in = 0, buf_wdata_out, gdata = 0, drv_data, g;
   logic data_oe_out, dreq_out, ata_dior_out, ata_diow_out, ata_dmack_out, ata_dmarq_in;
   logic iordy_in, buf_wr_out, buf_rd_out, buf_validate_out, buf_clear_out, buf_restart_out;
   logic core_reset_out, cmd_irq_out, rd_seen = 0, wq_on = 0;
   logic [2:0] tf_addr_out;
   logic [4:0] pvec;
   logic [31:0] v;
   logic [7:0] rq[$];
   logic [15:0] wq[$];
   logic [7:0] wcode[3] = '{8'h02, 8'h03, 8'h05};
   logic [2:0] wexp[3] = '{3'h4, 3'h7, 3'h3};
   int errors = 0, checks_done = 0;
   assign data_in = dack_in ? gdata : drv_data;
   assign pvec = {cmd_irq_out, core_reset_out, buf_restart_out, buf_clear_out, buf_validate_out};
   dma_command_and_transfer_counter dut (.mclk_in(mclk_in), .rst_in(rst_in),
      .bus_reset_in(bus_reset_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
      .rd_in(rd_in), .rd_data_out(rd_data_out), .data_in(data_in), .data_out(data_out),
      .data_oe_out(data_oe_out), .dreq_out(dreq_out), .dack_in(dack_in), .diow_in(diow_in),
      .dior_in(dior_in), .eot_in(eot_in), .ata_dior_out(ata_dior_out),
      .ata_diow_out(ata_diow_out), .ata_dmack_out(ata_dmack_out), .ata_dmarq_in(ata_dmarq_in),
      .iordy_in(iordy_in), .tf_addr_out(tf_addr_out), .buf_space_in(buf_space_in),
      .buf_avail_in(buf_avail_in), .buf_rdata_in(buf_rdata_in), .buf_wr_out(buf_wr_out),
      .buf_wdata_out(buf_wdata_out), .buf_rd_out(buf_rd_out),
      .buf_validate_out(buf_validate_out), .buf_clear_out(buf_clear_out),
      .buf_restart_out(buf_restart_out), .core_reset_out(core_reset_out),
      .cmd_irq_out(cmd_irq_out));
   ata_drive_model drv (.mclk_in(mclk_in), .rst_in(rst_in), .dior_in(ata_dior_out),
      .tf_in(tf_addr_out), .data_out(drv_data), .iordy_out(iordy_in), .dmarq_out(ata_dmarq_in));
   initial forever #5 mclk_in = ~mclk_in;
   // ****************
   // tasks
   // ****************
   task summarize;
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      wr_in <= 1;
      addr_in <= a;
      wr_data_in <= d;
      @(posedge mclk_in);
      wr_in <= 0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk_in);
      rd_in <= 1;
      addr_in <= a;
      rq.push_back(e);
      @(posedge mclk_in);
      rd_in <= 0;
   endtask : rd
   task cnt(input logic [31:0] c);
      for (int k = 0; k < 4; k++) wr(8'h34 + k, c[8*k+:8]);
   endtask : cnt
   task rdcnt(input logic [31:0] c);
      for (int k = 0; k < 4; k++) rd(8'h34 + k, c[8*k+:8]);
   endtask : rdcnt
   // bounded wait: pulse bit, 8 = request, 9 = queue drained, 10 = drive strobe, 11 = pop
   task wait_p(input int b);
      int i;
      logic c;
      for (i = 0; i < 300; i++) begin
         c = (b == 11) ? buf_rd_out : (b == 10) ? (ata_dior_out | ata_diow_out) :
            (b == 9) ? (wq.size() == 0) : (b == 8) ? dreq_out : pvec[b];
         if (c === 1'b1) break;
         @(posedge mclk_in);
      end
      if (i == 300) begin
         errors++;
         summarize();
      end
      chk(c, 1);
   endtask : wait_p
   task quiet(input int n);
      repeat (n) begin
         @(posedge mclk_in);
         chk({pvec, dreq_out, ata_dior_out, ata_diow_out, ata_dmack_out, data_oe_out}, 0);
      end
   endtask : quiet
   // ****************
   // result watcher
   // ****************
   always @(posedge mclk_in) begin
      if (rd_seen) chk(rd_data_out, rq.pop_front());
      rd_seen <= rd_in;
      if (wq_on && buf_wr_out === 1'b1) chk(buf_wdata_out, wq.size() ? wq.pop_front() : 16'hdead);
   end
   // ****************
   // main sequence
   // ****************
   initial begin
      void'($urandom(92));
      repeat (6) @(posedge mclk_in);
      rst_in <= 0;
      @(posedge mclk_in);
      chk(data_oe_out, 0);
      rd(8'h30, 8'hff);
      rd(8'h50, 8'h00);
      rdcnt(0);
      v = $urandom;
      for (int k = 0; k < 3; k++) wr(8'h34 + k, v[8*k+:8]);
      rd(8'h34, 8'h00);
      wr(8'h37, v[31:24]);
      rdcnt(v);
      @(posedge mclk_in) bus_reset_in <= 1;
      @(posedge mclk_in) bus_reset_in <= 0;
      rdcnt(0);
      for (int k = 0; k < 3; k++) begin
         wr(8'h30, 8'h0e + k);
         wait_p(k);
      end
      wr(8'h30, 8'h0d);
      wr(8'h30, 8'h13 + 8'($urandom % 237));
      quiet(30);
      // generic in with counter off, ended by end of transfer
      wr(8'h38, 8'h81);
      wr(8'h39, 8'h00);
      wr(8'h30, 8'h00);
      wait_p(8);
      g = $urandom;
      wq.push_back(g);
      wq_on = 1;
      @(posedge mclk_in);
      gdata <= g;
      dack_in <= 1;
      repeat (3) @(posedge mclk_in);
      diow_in <= 1;
      repeat (3) @(posedge mclk_in);
      diow_in <= 0;
      wait_p(9);
      repeat (3) @(posedge mclk_in);
      eot_in <= 1;
      wait_p(0);
      eot_in <= 0;
      dack_in <= 0;
      // pio read at 8-bit width still moves 2 bytes a word
      wr(8'h38, 8'h00);
      wr(8'h39, 8'h20);
      cnt(4);
      wq.push_back(16'ha500);
      wq.push_back(16'ha501);
      wr(8'h30, 8'h04);
      wait_p(9);
      repeat (8) @(posedge mclk_in);
      rdcnt(0);
      wq_on = 0;
      wr(8'h30, 8'h0b);
      @(posedge mclk_in);
      chk(tf_addr_out, 3'h7);
      wait_p(4);
      wr(8'h30, 8'h0c);
      wait_p(4);
      chk(tf_addr_out, 3'h6);
      // task-file byte count is taken as already set in the drive
      wr(8'h30, 8'h0a);
      wait_p(10);
      chk(tf_addr_out, 3'h0);
      repeat (8) @(posedge mclk_in);
      quiet(20);
      // one word each of ultra read, ultra write and pio write
      g = $urandom;
      buf_rdata_in <= g;
      foreach (wcode[k]) begin
         cnt(2);
         wr(8'h30, wcode[k]);
         wait_p(10);
         chk({ata_dmack_out, ata_diow_out, buf_rd_out}, wexp[k]);
         if (wcode[k] != 8'h02) chk({data_oe_out, data_out}, {1'b1, g});
         repeat (12) @(posedge mclk_in);
         rdcnt(0);
      end
      // multiword read stopped in its first strobe
      cnt(32'h40);
      wr(8'h30, 8'h06);
      wait_p(10);
      chk({ata_dmack_out, ata_dior_out}, 2'h3);
      wr(8'h30, 8'h12);
      quiet(20);
      rdcnt(32'h40);
      // generic out, one 16-bit word popped
      wr(8'h38, 8'h01);
      wr(8'h39, 8'h00);
      cnt(2);
      wr(8'h30, 8'h01);
      wait_p(8);
      dack_in <= 1;
      dior_in <= 1;
      repeat (4) @(posedge mclk_in);
      chk({data_oe_out, data_out}, {1'b1, g});
      dior_in <= 0;
      wait_p(11);
      dack_in <= 0;
      rdcnt(0);
      // generic request pulses while the core resets, then the count reads zero
      cnt($urandom);
      wr(8'h30, 8'h11);
      wait_p(8);
      wait_p(3);
      rdcnt(0);
      summarize();
   end
endmodule : dma_command_and_transfer_counter_tb
`default_nettype wire
